// *** hw/paper_jam_pkg.sv ***
// shared constants and carrier types for the paper jam alarm
package paper_jam_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_PER_MS = CLK_HZ / 1000;
	localparam int ON_LIMIT_MS = 480;
	localparam int ON_LIMIT_CYC = ON_LIMIT_MS * CLK_PER_MS;
	localparam int ON_CNT_W = 24;
	localparam logic [ON_CNT_W-1:0] ON_CNT_ZERO = 24'h000000;
	localparam logic [ON_CNT_W-1:0] ON_CNT_STEP = 24'h000001;

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	localparam int STAGES = 4;
	localparam logic [STAGES-1:0] COUNT_CLEAR = 4'h0;
	localparam logic [STAGES-1:0] COUNT_STEP = 4'h1;
	// terminal count of drive pulses, i.e. 27 or 28 line feeds
	localparam logic [STAGES-1:0] TERM_COUNT = 4'he;

	// ----------------------------------------------------------------
	// carriers and state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} sync_state_t;

	typedef struct packed {
		logic [ON_CNT_W-1:0] cnt;
		logic expired;
	} on_timer_state_t;

	typedef struct packed {
		logic drive;
		logic motor_on;
		logic manual_reset_n;
	} alarm_in_t;

	typedef struct packed {
		logic trip;
		logic interlock_closed;
		logic lamp;
	} alarm_out_t;

	typedef struct packed {
		logic [STAGES-1:0] stage;
		logic drive_prev;
		logic stage_clk_n;
		logic trip;
		logic interlock_closed;
		logic lamp;
	} alarm_state_t;

endpackage : paper_jam_pkg

// *** hw/pin_sync3.sv ***
// three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
	parameter logic INIT = 1'b0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// pin and clean level
	input wire logic pin,
	output logic level
);

	paper_jam_pkg::sync_state_t st_q;
	paper_jam_pkg::sync_state_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = pin;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3) begin
			st_d.level = st_q.s3;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= {4{INIT}};
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.level;

	a_sync_agree: assert property (@(posedge sys_clk) disable iff (!rstn)
		(st_q.level != $past(st_q.level)) |-> ($past(st_q.s2) == $past(st_q.s3)))
		else $error("synchronised level changed without agreement");

endmodule : pin_sync3

// *** hw/motor_on_time_limit.sv ***
// supply motor on-time limit timer
`timescale 1ns/1ps
module motor_on_time_limit #(
	parameter int ON_LIMIT_CYCLES = paper_jam_pkg::ON_LIMIT_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// motor level and limit flag
	input wire logic motor_on,
	output logic expired
);

	localparam logic [paper_jam_pkg::ON_CNT_W-1:0] LIMIT =
		paper_jam_pkg::ON_CNT_W'(ON_LIMIT_CYCLES);

	paper_jam_pkg::on_timer_state_t st_q;
	paper_jam_pkg::on_timer_state_t st_d;

	always_comb begin
		st_d = st_q;
		if (!motor_on) begin
			st_d.cnt = paper_jam_pkg::ON_CNT_ZERO;
			st_d.expired = 1'b0;
		end else if (st_q.cnt == LIMIT) begin
			st_d.expired = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + paper_jam_pkg::ON_CNT_STEP;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign expired = st_q.expired;

	a_limit_expire: assert property (@(posedge sys_clk) disable iff (!rstn)
		(motor_on && st_q.cnt == LIMIT) |=> expired)
		else $error("on-time limit reached without expiry");

	a_off_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
		!motor_on |=> (st_q.cnt == paper_jam_pkg::ON_CNT_ZERO) && !expired)
		else $error("on-time measure not restarted after motor off");

endmodule : motor_on_time_limit

// *** hw/paper_jam_alarm_counter.sv ***
// paper jam and paper out alarm: drive pulse counter, on-time limit, trip latch
`timescale 1ns/1ps
module paper_jam_alarm_counter #(
	parameter int ON_LIMIT_CYCLES = paper_jam_pkg::ON_LIMIT_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// pins from magnet driver, motor sense and operator
	input wire logic drive_pulse_in,
	input wire logic supply_motor_on_in,
	input wire logic manual_reset_n_in,
	// alarm outputs
	output paper_jam_pkg::alarm_out_t alarm,
	output logic [paper_jam_pkg::STAGES-1:0] count_stages
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	paper_jam_pkg::alarm_in_t pins;

	pin_sync3 #(.INIT(1'b0)) sync_drive (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.pin(drive_pulse_in),
		.level(pins.drive)
	);

	pin_sync3 #(.INIT(1'b0)) sync_motor (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.pin(supply_motor_on_in),
		.level(pins.motor_on)
	);

	pin_sync3 #(.INIT(1'b1)) sync_manual (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.pin(manual_reset_n_in),
		.level(pins.manual_reset_n)
	);

	// ----------------------------------------------------------------
	// on-time limit
	// ----------------------------------------------------------------
	logic motor_on_time_limit_hit;

	motor_on_time_limit #(.ON_LIMIT_CYCLES(ON_LIMIT_CYCLES)) on_timer (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.motor_on(pins.motor_on),
		.expired(motor_on_time_limit_hit)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	paper_jam_pkg::alarm_state_t st_q;
	paper_jam_pkg::alarm_state_t st_d;

	// ----------------------------------------------------------------
	// terminal decode, one tap per stage
	// ----------------------------------------------------------------
	logic [paper_jam_pkg::STAGES-1:0] decode_taps;
	logic terminal;

	for (genvar i = 0; i < paper_jam_pkg::STAGES; i++) begin : g_tap
		// true output where the terminal code has a one, inverted elsewhere
		assign decode_taps[i] = paper_jam_pkg::TERM_COUNT[i] ? st_q.stage[i] : ~st_q.stage[i];
	end

	assign terminal = &decode_taps;

	// ----------------------------------------------------------------
	// pulse shaping and clear terms
	// ----------------------------------------------------------------
	logic first_stage_clock_in;
	logic motor_on_count_clear;
	logic manual_clear;
	logic trip_set;

	// one low strobe per rising edge of the magnet drive level
	assign first_stage_clock_in = st_q.stage_clk_n;
	assign motor_on_count_clear = pins.motor_on;
	assign manual_clear = ~pins.manual_reset_n;
	assign trip_set = terminal | motor_on_time_limit_hit;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.drive_prev = pins.drive;
		// each driver pulse spans two line feeds
		st_d.stage_clk_n = ~(pins.drive & ~st_q.drive_prev);
		if (manual_clear || motor_on_count_clear) begin
			st_d.stage = paper_jam_pkg::COUNT_CLEAR;
		end else if (!first_stage_clock_in && !st_q.trip) begin
			// frozen while tripped, so the count cannot wrap
			st_d.stage = st_q.stage + paper_jam_pkg::COUNT_STEP;
		end
		// set wins over the manual clear
		st_d.trip = trip_set | (st_q.trip & ~manual_clear);
		st_d.interlock_closed = ~st_d.trip;
		st_d.lamp = st_d.trip;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '{stage: paper_jam_pkg::COUNT_CLEAR, drive_prev: 1'b0,
				stage_clk_n: 1'b1, trip: 1'b0, interlock_closed: 1'b1, lamp: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign alarm.trip = st_q.trip;
	assign alarm.interlock_closed = st_q.interlock_closed;
	assign alarm.lamp = st_q.lamp;
	assign count_stages = st_q.stage;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	a_decode_taps: assert property (
		terminal == (st_q.stage == paper_jam_pkg::TERM_COUNT))
		else $error("terminal decode disagrees with count");

	a_term_trip: assert property (
		(st_q.stage == paper_jam_pkg::TERM_COUNT) |=> alarm.trip)
		else $error("terminal count did not trip");

	a_count_step: assert property (
		(!first_stage_clock_in && !st_q.trip && !manual_clear && !motor_on_count_clear)
		|=> (st_q.stage == $past(st_q.stage) + paper_jam_pkg::COUNT_STEP))
		else $error("count did not advance on drive strobe");

	a_edge_strobe: assert property (
		$rose(pins.drive) |=> !first_stage_clock_in ##1 first_stage_clock_in)
		else $error("drive edge not shaped into one low strobe");

	a_motor_clear: assert property (
		motor_on_count_clear |=> (st_q.stage == paper_jam_pkg::COUNT_CLEAR))
		else $error("motor turn-on did not clear count");

	a_trip_outputs: assert property (
		alarm.trip |-> (!alarm.interlock_closed && alarm.lamp))
		else $error("tripped without open interlock and lamp");

	a_trip_holds: assert property (
		(alarm.trip && !manual_clear) |=> (alarm.trip && ($stable(st_q.stage)
			|| st_q.stage == paper_jam_pkg::COUNT_CLEAR)))
		else $error("trip released or count moved without reset");

	a_manual_release: assert property (
		(manual_clear && !trip_set) |=> (!alarm.trip && alarm.interlock_closed && !alarm.lamp
			&& st_q.stage == paper_jam_pkg::COUNT_CLEAR))
		else $error("manual reset did not release");

	a_on_limit_trip: assert property (
		motor_on_time_limit_hit |=> alarm.trip ##1 (alarm.trip || $past(manual_clear)))
		else $error("on-time expiry did not trip");

	a_release_cause: assert property (
		$fell(alarm.trip) |-> $past(manual_clear) && alarm.interlock_closed)
		else $error("trip fell without manual reset");

	// ----------------------------------------------------------------
	// checks: strobe shaping
	// ----------------------------------------------------------------
	a_strobe_width: assert property (
		!first_stage_clock_in |=> first_stage_clock_in)
		else $error("drive strobe longer than one cycle");

	a_strobe_cause: assert property (
		!first_stage_clock_in |-> ($past(pins.drive) && !$past(st_q.drive_prev)))
		else $error("drive strobe without rising drive level");

	a_prev_follows: assert property (
		st_q.drive_prev == $past(pins.drive))
		else $error("previous drive level not tracked");

	a_strobe_idle: assert property (
		!pins.drive |=> first_stage_clock_in)
		else $error("drive strobe while drive level low");

	// ----------------------------------------------------------------
	// checks: count movement
	// ----------------------------------------------------------------
	a_count_hold: assert property (
		(first_stage_clock_in && !manual_clear && !motor_on_count_clear)
		|=> $stable(st_q.stage))
		else $error("count moved without drive strobe");

	a_count_only_up: assert property (
		(st_q.stage != $past(st_q.stage)) |-> (st_q.stage == paper_jam_pkg::COUNT_CLEAR
			|| st_q.stage == $past(st_q.stage) + paper_jam_pkg::COUNT_STEP))
		else $error("count moved other than up by one or to zero");

	a_step_needs_strobe: assert property (
		(st_q.stage != $past(st_q.stage) && st_q.stage != paper_jam_pkg::COUNT_CLEAR)
		|-> (!$past(first_stage_clock_in) && !$past(st_q.trip)))
		else $error("count advanced without strobe or while tripped");

	a_frozen_trip: assert property (
		(st_q.trip && !manual_clear && !motor_on_count_clear) |=> $stable(st_q.stage))
		else $error("count moved while tripped");

	a_no_wrap: assert property (
		st_q.stage <= paper_jam_pkg::TERM_COUNT)
		else $error("count passed the terminal code");

	a_manual_clear_stage: assert property (
		manual_clear |=> (st_q.stage == paper_jam_pkg::COUNT_CLEAR))
		else $error("manual reset did not clear count");

	a_motor_hold: assert property (
		(motor_on_count_clear && $past(motor_on_count_clear))
		|-> (st_q.stage == paper_jam_pkg::COUNT_CLEAR))
		else $error("count not held at zero while motor on");

	// ----------------------------------------------------------------
	// checks: trip path and outputs
	// ----------------------------------------------------------------
	a_term_lamp: assert property (
		(st_q.stage == paper_jam_pkg::TERM_COUNT) |=> alarm.lamp)
		else $error("terminal count did not light lamp");

	a_term_interlock: assert property (
		(st_q.stage == paper_jam_pkg::TERM_COUNT) |=> !alarm.interlock_closed)
		else $error("terminal count did not open interlock");

	a_lamp_follows: assert property (
		alarm.lamp == alarm.trip)
		else $error("lamp differs from trip state");

	a_interlock_inverse: assert property (
		alarm.interlock_closed == !alarm.trip)
		else $error("interlock not the inverse of trip");

	a_trip_cause: assert property (
		$rose(alarm.trip) |-> $past(trip_set))
		else $error("trip rose without a cause");

	a_no_cause_idle: assert property (
		(!trip_set && !st_q.trip) |=> !alarm.trip)
		else $error("trip set without terminal count or expiry");

	a_set_wins: assert property (
		(trip_set && manual_clear) |=> alarm.trip)
		else $error("manual reset beat a present trip cause");

	a_trip_stays: assert property (
		(alarm.trip && !manual_clear) |=> alarm.trip)
		else $error("trip dropped without manual reset");

	a_interlock_opens: assert property (
		$rose(alarm.trip) |-> !alarm.interlock_closed)
		else $error("interlock still closed on trip");

	a_lamp_lights: assert property (
		$rose(alarm.trip) |-> alarm.lamp)
		else $error("lamp dark on trip");

	a_release_lamp: assert property (
		$fell(alarm.trip) |-> (!alarm.lamp && alarm.interlock_closed))
		else $error("release left lamp lit or interlock open");

	a_expiry_needs_motor: assert property (
		motor_on_time_limit_hit |-> $past(pins.motor_on))
		else $error("on-time expiry with motor off");

endmodule : paper_jam_alarm_counter

// *** test/feed_driver_model.sv ***
// line feed magnet driver model giving one count pulse per two feeds
`timescale 1ns/1ps
module feed_driver_model (
	// clock
	input wire logic sys_clk,
	// feed strobe and start state
	input wire logic feed,
	input wire logic start_high,
	input wire logic load,
	// count pulse pin
	output logic drive
);
	logic phase_q;
	logic [2:0] hold_q;

	// changes on the falling edge, away from the block's sampling edge
	always_ff @(negedge sys_clk) begin
		if (load) begin
			phase_q <= start_high;
			hold_q <= 3'h0;
		end else if (feed) begin
			phase_q <= ~phase_q;
			hold_q <= phase_q ? 3'h0 : 3'h4;
		end else if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
		end
	end
	assign drive = (hold_q != 3'h0);
endmodule : feed_driver_model

// *** test/tb_top.sv ***
// self-checking bench for the paper jam alarm counter
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------------------------------
	// bench signals
	// ----------------------------------------------------------------
	localparam int LIM = 20;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic motor = 1'b0;
	logic man_n = 1'b1;
	logic feed = 1'b0;
	logic start_high = 1'b0;
	logic load = 1'b1;
	logic drive;
	paper_jam_pkg::alarm_out_t alarm;
	logic [3:0] cnt;
	int mismatches = 0;
	int tests_run = 0;

	always #20 sys_clk = ~sys_clk;

	feed_driver_model drv (.sys_clk(sys_clk), .feed(feed), .start_high(start_high),
		.load(load), .drive(drive));
	paper_jam_alarm_counter #(.ON_LIMIT_CYCLES(LIM)) dut (.sys_clk(sys_clk), .rstn(rstn),
		.drive_pulse_in(drive), .supply_motor_on_in(motor), .manual_reset_n_in(man_n),
		.alarm(alarm), .count_stages(cnt));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc

	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_cnt(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_cnt

	task automatic chk_alarm(input logic tripped);
		chk_bit(alarm.trip, tripped);
		chk_bit(alarm.lamp, tripped);
		chk_bit(alarm.interlock_closed, ~tripped);
	endtask : chk_alarm

	// one feed strobe, then room for the pulse and its low time
	task automatic feeds(input int n);
		repeat (n) begin
			feed <= 1'b1;
			cyc(1);
			feed <= 1'b0;
			cyc(9);
		end
	endtask : feeds

	task automatic op_reset();
		man_n = 1'b0;
		cyc(8);
		man_n = 1'b1;
		cyc(8);
	endtask : op_reset

	task automatic close_out();
		if (mismatches == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_count(input logic st);
		op_reset();
		start_high <= st;
		load <= 1'b1;
		cyc(2);
		load <= 1'b0;
		cyc(1);
		feeds(26 + int'(st));
		chk_cnt(cnt, 4'hd);
		chk_alarm(1'b0);
		feeds(1);
		chk_cnt(cnt, 4'he);
		chk_alarm(1'b1);
		feeds(6);
		chk_cnt(cnt, 4'he);
		chk_alarm(1'b1);
		op_reset();
		chk_cnt(cnt, 4'h0);
		chk_alarm(1'b0);
		feeds(2);
		chk_cnt(cnt, 4'h1);
	endtask : t_count

	task automatic t_motor();
		feeds(10);
		chk_cnt(cnt, 4'h6);
		motor = 1'b1;
		cyc(12);
		chk_cnt(cnt, 4'h0);
		motor = 1'b0;
		cyc(10);
		motor = 1'b1;
		cyc(18);
		motor = 1'b0;
		cyc(10);
		chk_alarm(1'b0);
		motor = 1'b1;
		cyc(LIM + 12);
		chk_alarm(1'b1);
		motor = 1'b0;
		op_reset();
		chk_alarm(1'b0);
	endtask : t_motor

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		cyc(12);
		rstn = 1'b1;
		cyc(2);
		chk_cnt(cnt, 4'h0);
		chk_alarm(1'b0);
		t_count(1'b0);
		t_count(1'b1);
		t_motor();
		close_out();
	end

	initial begin
		cyc(20000);
		mismatches++;
		close_out();
	end
endmodule : tb_top
